// ==== verilog/sar_ctrl_map.vh ====
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef SAR_CTRL_MAP_VH
`define SAR_CTRL_MAP_VH
// register indices; byte address is four times the index
`define IDX_CONFIG 8'hBC
`define IDX_RESULT_LOW 8'hBD
`define IDX_RESULT_HIGH 8'hBE
`define IDX_CONTROL 8'hBF
// control register fields
`define CTL_ENABLE 7
`define CTL_DELAY_TRACK 6
`define CTL_DONE 5
`define CTL_BUSY 4
`define CTL_SRC_HI 2
`define CTL_SRC_LO 0
// configuration register fields
`define CFG_DIV_HI 7
`define CFG_DIV_LO 3
`define CFG_LEFT 2
`define CFG_EIGHT 1
`define CFG_GAIN 0
// reset values
`define RST_CONFIG 8'hF8
`define RST_CONTROL 8'h00
`define RST_RESULT 8'h00
// start source codes
`define SRC_SOFTWARE 3'h0
`define SRC_TIMER0 3'h1
`define SRC_TIMER2 3'h2
`define SRC_TIMER1 3'h3
`define SRC_EXT_PIN 3'h4
`define SRC_TIMER3 3'h5
// timing counts in sar clocks
`define DELAY_TRACK_TICKS 4'h3
`define CONV_TICKS_TEN 4'hD
`define CONV_TICKS_EIGHT 4'hB
`define BITS_TEN 4'hA
`define BITS_EIGHT 4'h8
`endif

// ==== verilog/sar_adc_conversion_control.v ====
// conversion control of a 10-bit successive approximation converter with an ahb-lite slave
//
// Chosen here: the register addresses and register access over AHB-Lite.
`include "sar_ctrl_map.vh"
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control (
	input wire hclk, // system clock, 250 MHz
	input wire hresetn, // asynchronous reset, active low
	input wire hsel, // slave select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write when high
	input wire [2:0] hsize, // transfer size, word only
	input wire [31:0] hwdata, // write data
	input wire hready, // bus ready
	output wire hreadyout, // slave ready, always high
	output wire hresp, // response, always okay
	output reg [31:0] hrdata, // read data
	input wire timer0_ovf, // timer 0 overflow pulse
	input wire timer1_ovf, // timer 1 overflow pulse
	input wire timer2_low_ovf, // timer 2 low byte overflow pulse
	input wire timer2_high_ovf, // timer 2 high byte overflow pulse
	input wire timer2_split, // timer 2 runs as 8-bit timers
	input wire timer3_low_ovf, // timer 3 low byte overflow pulse
	input wire timer3_high_ovf, // timer 3 high byte overflow pulse
	input wire timer3_split, // timer 3 runs as 8-bit timers
	input wire external_convert_start, // external start pin level
	input wire comparator_in, // high when input at or above trial code
	input wire done_irq_enable, // interrupt enable from system
	output wire converter_powered, // analog part out of shutdown
	output wire track_active, // track and hold is tracking
	output wire [9:0] dac_trial_code, // trial code to the capacitor dac
	output wire gain_one, // gain select to analog stage
	output wire done_irq // interrupt request, level
);
	// sequencing overview:
	// idle tracks the input while enabled, except with the pin source, delay bit clear and pin high, and a trigger accepted there starts a conversion
	// the delay state spends three sar ticks still tracking before the trials
	// the convert state trials one bit per sar tick, msb first
	// the remaining ticks of a conversion only let the result settle
	// the result bytes and the done flag load together on the last tick
	// clearing the enable bit drops back to idle, keeping the old result
	// triggers that arrive while busy or shut down are dropped, never queued
	// eight-bit mode is latched per conversion; divider and justify act live
	// a hardware set of the done flag wins over a software clear in one cycle
	// busy reads 0 as soon as the enable bit is cleared
	// bus side:
	// zero wait states, the slave never stretches a transfer
	// write data is taken in the data phase, read data is registered
	// writes decode only the word index bits; reads also need the upper address bits zero
	// a read straight after a write to the same register sees the old value
	localparam ST_IDLE = 2'h0; // tracking, shut down, or holding on a high start pin
	localparam ST_DELAY = 2'h1; // extra tracking ticks
	localparam ST_CONV = 2'h2; // bit trials

	// register state
	reg [7:0] config_q; // configuration register
	reg converter_enable_bit_q; // enable bit
	reg delayed_track_enable_q; // delayed tracking bit
	reg conversion_done_flag_q; // done flag
	reg [2:0] start_source_select_q; // start source
	reg [7:0] result_high_byte_q; // result high byte
	reg [7:0] result_low_byte_q; // result low byte
	reg [1:0] state_q; // sequencer state
	reg [4:0] div_cnt_q; // sar clock divider count
	reg [3:0] tick_q; // sar ticks in current phase
	reg [9:0] code_q; // successive approximation register
	reg [3:0] bit_q; // bit under trial
	reg eight_q; // eight-bit mode latched at start
	reg pin_prev_q; // last pin level for edge detect
	reg wr_pend_q; // write data phase pending
	reg [7:0] wr_idx_q; // index of pending write

	// decoded fields and sequencer strobes
	wire [4:0] sar_clock_divider = config_q[`CFG_DIV_HI:`CFG_DIV_LO]; // divider field
	wire left_justify_select = config_q[`CFG_LEFT]; // justify select
	wire eight_bit_mode_enable = config_q[`CFG_EIGHT]; // eight-bit mode
	wire busy = converter_enable_bit_q && (state_q != ST_IDLE); // 0 once shut down
	wire sar_tick = busy && (div_cnt_q == sar_clock_divider); // one sar clock
	wire [3:0] total_ticks = eight_q ? `CONV_TICKS_EIGHT : `CONV_TICKS_TEN;
	wire [3:0] lsb_pos = eight_q ? 4'h2 : 4'h0; // last bit to trial
	wire finish = (state_q == ST_CONV) && sar_tick && (tick_q == total_ticks - 4'h1);
	wire addr_take = hsel && htrans[1] && hready; // valid address phase
	wire [7:0] addr_idx = haddr[9:2]; // word index
	wire ctl_wr = wr_pend_q && (wr_idx_q == `IDX_CONTROL); // control write in data phase
	wire sw_start = ctl_wr && hwdata[`CTL_BUSY]; // software start request
	reg trigger; // selected trigger pulse

	// fixed bus answers and analog side outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign converter_powered = converter_enable_bit_q;
	assign dac_trial_code = code_q;
	assign gain_one = config_q[`CFG_GAIN];
	assign done_irq = conversion_done_flag_q && done_irq_enable;
	// tracking: internal sources when idle, pin source per delay bit and pin level
	assign track_active = converter_enable_bit_q && ((state_q == ST_DELAY) ||
		((state_q == ST_IDLE) && ((start_source_select_q != `SRC_EXT_PIN) ||
		delayed_track_enable_q || !external_convert_start)));

	// result formatting for both justifications and eight-bit mode
	function [15:0] format_result;
		input [9:0] code;
		input eight;
		input left;
		begin
			// eight-bit mode ignores the justify select
			if (eight) begin
				format_result = {code[9:2], 8'h00};
			end else if (left) begin
				format_result = {code, 6'h00};
			end else begin
				format_result = {6'h00, code};
			end
		end
	endfunction

	// trigger selection
	always @* begin
		trigger = 1'b0;
		case (start_source_select_q)
			`SRC_SOFTWARE: trigger = sw_start;
			`SRC_TIMER0: trigger = timer0_ovf;
			// timers 2 and 3 follow their split mode
			`SRC_TIMER2: trigger = timer2_split ? timer2_low_ovf : timer2_high_ovf;
			`SRC_TIMER1: trigger = timer1_ovf;
			// the pin source fires on a low to high step only
			`SRC_EXT_PIN: trigger = external_convert_start && !pin_prev_q;
			`SRC_TIMER3: trigger = timer3_split ? timer3_low_ovf : timer3_high_ovf;
			default: trigger = 1'b0;
		endcase
	end

	// ahb address phase capture and registered read data
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			// remember a write for its data phase
			wr_pend_q <= addr_take && hwrite;
			wr_idx_q <= addr_idx;
			// read data is captured in the address phase
			if (addr_take && !hwrite) begin
				if (haddr[31:10] != 22'h000000) begin
					hrdata <= 32'h00000000; // unmapped reads zero
				end else if (addr_idx == `IDX_CONFIG) begin
					hrdata <= {24'h000000, config_q};
				end else if (addr_idx == `IDX_RESULT_LOW) begin
					hrdata <= {24'h000000, result_low_byte_q};
				end else if (addr_idx == `IDX_RESULT_HIGH) begin
					hrdata <= {24'h000000, result_high_byte_q};
				end else if (addr_idx == `IDX_CONTROL) begin
					hrdata <= {24'h000000, converter_enable_bit_q, delayed_track_enable_q,
						conversion_done_flag_q, busy, 1'b0, start_source_select_q};
				end else begin
					hrdata <= 32'h00000000;
				end
			end
		end
	end

	// software writable registers and done flag
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_q <= `RST_CONFIG;
			converter_enable_bit_q <= 1'b0;
			delayed_track_enable_q <= 1'b0;
			conversion_done_flag_q <= 1'b0;
			start_source_select_q <= 3'h0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= external_convert_start;
			// configuration takes the whole byte
			if (wr_pend_q && (wr_idx_q == `IDX_CONFIG)) begin
				config_q <= hwdata[7:0];
			end
			// busy is not stored from this write; it only requests a start
			if (ctl_wr) begin
				converter_enable_bit_q <= hwdata[`CTL_ENABLE];
				delayed_track_enable_q <= hwdata[`CTL_DELAY_TRACK];
				start_source_select_q <= hwdata[`CTL_SRC_HI:`CTL_SRC_LO];
			end
			// hardware set wins over a software write
			if (finish) begin
				conversion_done_flag_q <= 1'b1;
			end else if (ctl_wr) begin
				conversion_done_flag_q <= hwdata[`CTL_DONE];
			end
		end
	end

	// sar clock divider, restarted on each accepted trigger
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_q <= 5'h00;
		// counts only while busy, so each conversion starts on a fresh phase
		end else if (!busy || sar_tick) begin
			div_cnt_q <= 5'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 5'h01;
		end
	end

	// conversion sequencer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			tick_q <= 4'h0;
			code_q <= 10'h000;
			bit_q <= 4'h9;
			eight_q <= 1'b0;
			result_high_byte_q <= `RST_RESULT;
			result_low_byte_q <= `RST_RESULT;
		end else begin
			// result bytes are writable by software as well
			if (wr_pend_q && (wr_idx_q == `IDX_RESULT_LOW)) begin
				result_low_byte_q <= hwdata[7:0];
			end
			if (wr_pend_q && (wr_idx_q == `IDX_RESULT_HIGH)) begin
				result_high_byte_q <= hwdata[7:0];
			end
			if (!converter_enable_bit_q) begin
				// abort leaves the result and the done flag untouched
				state_q <= ST_IDLE; // shutdown aborts
				tick_q <= 4'h0;
			end else begin
				case (state_q)
					ST_IDLE: begin
						// triggers only count here
						if (trigger) begin
							tick_q <= 4'h0;
							// first trial is the midpoint, msb set
							code_q <= 10'h200;
							bit_q <= 4'h9;
							eight_q <= eight_bit_mode_enable;
							if (delayed_track_enable_q) begin
								state_q <= ST_DELAY;
							end else begin
								state_q <= ST_CONV;
							end
						end
					end
					ST_DELAY: begin
						if (sar_tick) begin
							// count the extra tracking ticks
							if (tick_q == `DELAY_TRACK_TICKS - 4'h1) begin
								tick_q <= 4'h0;
								state_q <= ST_CONV;
							end else begin
								tick_q <= tick_q + 4'h1;
							end
						end
					end
					ST_CONV: begin
						if (sar_tick) begin
							tick_q <= tick_q + 4'h1;
							// bit trials in the first ticks, then settle to the end
							if (tick_q < (eight_q ? `BITS_EIGHT : `BITS_TEN)) begin
								// the comparator decides the bit under trial
								if (!comparator_in) begin
									code_q[bit_q] <= 1'b0;
								end
								// arm the next lower bit as the new trial
								if (bit_q != lsb_pos) begin
									code_q[bit_q - 4'h1] <= 1'b1;
									bit_q <= bit_q - 4'h1;
								end
							end
							if (finish) begin
								{result_high_byte_q, result_low_byte_q} <=
									format_result(code_q, eight_q, left_justify_select);
								state_q <= ST_IDLE;
							end
						end
					end
					default: begin
						// unused state code falls back to idle
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/analog_side.sv ====
// ideal comparator standing in for the analog front end
`timescale 1ns/1ps
`default_nettype none
module analog_side (
	input wire logic [9:0] level, // held input as a code
	input wire logic [9:0] trial, // trial code from the converter
	output logic comparator_in // high when input at or above trial
);
	// no offset or noise, so the search lands exactly on the input code
	assign comparator_in = level >= trial;
endmodule
`default_nettype wire

// ==== dv/sar_ctrl_checker.sv ====
// port assertions for the converter control
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_checker (
	input wire hclk, // system clock
	input wire hresetn, // reset, active low
	input wire hsel, // slave select
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write transfer
	input wire hreadyout, // slave ready
	input wire hresp, // response
	input wire [31:0] hrdata, // read data
	input wire done_irq_enable, // request enable
	input wire converter_powered, // out of shutdown
	input wire track_active, // tracking
	input wire [9:0] dac_trial_code, // trial code
	input wire done_irq // request
);
	logic wr_q; // a write data phase runs now
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// mark the data phase of each write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_q <= 1'b0;
		else
			wr_q <= hsel && htrans[1] && hwrite;
	end
	AST_BUS: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
	AST_UPPER: assert property (hrdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	AST_SHUT: assert property (!converter_powered |-> !track_active)
		else $error("tracking in shutdown");
	AST_FROZEN: assert property (
		!converter_powered ##1 !converter_powered |-> $stable(dac_trial_code))
		else $error("trial code moved in shutdown");
	AST_IRQ: assert property (done_irq |-> done_irq_enable)
		else $error("request while masked");
	AST_CAUSE: assert property (
		$rose(done_irq) && $past(done_irq_enable) |-> !$past(track_active))
		else $error("done raised without a conversion ending");
	AST_LONG: assert property (
		$fell(track_active) && converter_powered |-> !track_active [*8])
		else $error("conversion too short");
	AST_HOLD: assert property (done_irq && !wr_q ##1 done_irq_enable |-> done_irq)
		else $error("done flag lost without a write");
endmodule
bind sar_adc_conversion_control sar_ctrl_checker checker_i (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .done_irq_enable(done_irq_enable), .converter_powered(converter_powered),
	.track_active(track_active), .dac_trial_code(dac_trial_code), .done_irq(done_irq));
`default_nettype wire

// ==== dv/sar_adc_conversion_control_bench.sv ====
// self-checking bench: register tasks drive the converter control
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctrl_map.vh"
module sar_adc_conversion_control_bench;
	logic hclk = 1'b0; // system clock
	logic hresetn = 1'b0; // reset, active low
	logic hsel = 1'b0; // slave select
	logic hwrite = 1'b0; // write transfer
	logic pin = 1'b0; // start pin, wired to nothing else
	logic irq_en = 1'b1; // request enable
	logic split = 1'b0; // timers 2 and 3 in 8-bit mode
	logic [1:0] htrans = 2'h0; // transfer type
	logic [31:0] haddr = 32'h0; // byte address
	logic [31:0] hwdata = 32'h0; // write data
	logic [5:0] trig = 6'h00; // timer overflow pulses
	logic [9:0] level = 10'h155; // input code
	logic [31:0] rd, hi, lo; // read data, measured spans
	wire hready, hresp, comp, powered, track, irq, gain; // converter and comparator outputs
	wire [31:0] hrdata; // read data
	wire [9:0] trial; // trial code
	int failures = 0; // mismatches
	int checks_done = 0; // comparisons
	int n; // wait count
	logic [7:0] fcfg [4] = '{8'h00, 8'h04, 8'h04, 8'h06}; // right, left, left, eight-bit
	logic [9:0] flvl [4] = '{10'h3FF, 10'h3FF, 10'h200, 10'h2C5};
	logic [7:0] fhi [4] = '{8'h03, 8'hFF, 8'h80, 8'hB1};
	logic [7:0] flo [4] = '{8'hFF, 8'hC0, 8'h00, 8'h00};
	logic [7:0] sid [7] = '{8'h01, 8'h03, 8'h02, 8'h02, 8'h05, 8'h05, 8'h04}; // sources
	int sbad [7] = '{1, 0, 3, 2, 5, 4, 0}; // a trigger the source must not take
	logic ssp [7] = '{0, 0, 1, 0, 1, 0, 0};
	logic [7:0] tcfg [4] = '{8'h01, 8'h10, 8'h12, 8'h08}; // dividers 0, 2, 2, 1
	logic [7:0] tctl [4] = '{8'h90, 8'h90, 8'h90, 8'hD0};
	logic [31:0] thi [4] = '{0, 0, 0, 6};
	logic [31:0] tlo [4] = '{13, 39, 33, 26};
	sar_adc_conversion_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .timer0_ovf(trig[0]),
		.timer1_ovf(trig[1]), .timer2_low_ovf(trig[2]), .timer2_high_ovf(trig[3]),
		.timer2_split(split), .timer3_low_ovf(trig[4]), .timer3_high_ovf(trig[5]),
		.timer3_split(split), .external_convert_start(pin), .comparator_in(comp),
		.done_irq_enable(irq_en), .converter_powered(powered), .track_active(track),
		.dac_trial_code(trial), .gain_one(gain), .done_irq(irq));
	analog_side far (.level(level), .trial(trial), .comparator_in(comp));
	initial begin
		forever #2 hclk = ~hclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// a wait that ran out ends the run
	task bail(input logic c);
		if (c) begin
			failures++;
			test_done;
		end
	endtask
	// next edge with ready sampled high
	task step;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		bail(n >= 50);
	endtask
	// one single word transfer; read data lands in rd
	task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		step;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		step;
		rd = hrdata;
	endtask
	// poll the done flag, as software should
	task wait_done;
		int k;
		k = 0;
		do begin
			xfer(1'b0, `IDX_CONTROL, 8'h00);
			k++;
		end while (rd[5] !== 1'b1 && k < 300); // done flag, not busy
		bail(k >= 300);
	endtask
	// cycles of tracking, then of converting, after a start
	task meas;
		hi = 0;
		lo = 0;
		#1;
		while (track === 1'b1 && hi < 500) begin
			hi++;
			@(posedge hclk);
			#1;
		end
		while (track === 1'b0 && lo < 500) begin
			lo++;
			@(posedge hclk);
			#1;
		end
		bail(lo >= 500);
		@(posedge hclk);
	endtask
	// one overflow pulse, or the pin raised and held
	task fire(input int k);
		if (k == 6)
			pin <= 1'b1;
		else
			trig <= 6'h01 << k;
		@(posedge hclk);
		trig <= 6'h00;
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, `IDX_CONFIG, 8'h00);
		chk(rd, {24'h0, `RST_CONFIG});
		xfer(1'b0, `IDX_CONTROL, 8'h00);
		chk(rd, {24'h0, `RST_CONTROL});
		xfer(1'b0, 8'h00, 8'h00);
		chk(rd, 32'h0);
		$display("reset test done");
		xfer(1'b1, `IDX_CONTROL, 8'h80);
		for (int i = 0; i < 4; i++) begin
			level <= flvl[i];
			xfer(1'b1, `IDX_CONFIG, fcfg[i]);
			xfer(1'b1, `IDX_CONTROL, 8'h90);
			wait_done;
			chk({31'h0, irq}, 32'h1);
			xfer(1'b0, `IDX_RESULT_HIGH, 8'h00);
			chk(rd, {24'h0, fhi[i]});
			xfer(1'b0, `IDX_RESULT_LOW, 8'h00);
			chk(rd, {24'h0, flo[i]});
			xfer(1'b1, `IDX_CONTROL, 8'h80);
		end
		$display("format test done");
		for (int i = 0; i < 7; i++) begin
			split <= ssp[i];
			xfer(1'b1, `IDX_CONTROL, 8'h80 | sid[i]);
			fire(sbad[i]);
			xfer(1'b0, `IDX_CONTROL, 8'h00);
			chk(rd, {24'h0, 8'h80 | sid[i]});
			fire(i);
			@(posedge hclk);
			fire(i); // a second trigger while busy is dropped
			wait_done;
			chk(rd, {24'h0, 8'hA0 | sid[i]});
			pin <= 1'b0;
			xfer(1'b1, `IDX_CONTROL, 8'h80 | sid[i]);
		end
		$display("source test done");
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `IDX_CONFIG, tcfg[i]);
			xfer(1'b1, `IDX_CONTROL, tctl[i] & 8'hEF);
			chk({31'h0, gain}, {31'h0, tcfg[i][0]});
			xfer(1'b1, `IDX_CONTROL, tctl[i]);
			meas;
			chk(hi, thi[i]);
			chk(lo, tlo[i]);
			xfer(1'b1, `IDX_CONTROL, 8'h80);
		end
		$display("timing test done");
		xfer(1'b1, `IDX_CONTROL, 8'h90);
		xfer(1'b1, `IDX_CONTROL, 8'h00);
		xfer(1'b0, `IDX_CONTROL, 8'h00);
		chk(rd, 32'h0);
		chk({30'h0, powered, track}, 32'h0);
		irq_en <= 1'b0;
		xfer(1'b1, `IDX_CONTROL, 8'h80);
		xfer(1'b1, `IDX_CONTROL, 8'h90);
		wait_done;
		chk({31'h0, irq}, 32'h0);
		irq_en <= 1'b1;
		@(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		$display("abort and request test done");
		test_done;
	end
endmodule
`default_nettype wire
